/* bench/acst_tb_top.sv */
// Self-checking testbench for the channel sequence table
`timescale 1ns/1ps
`default_nettype none
module acst_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic conv_done = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic [4:0] slot_channel;
  logic [4:0] slot_index;
  logic slot_last;
  logic seq_running;
  logic seq_wrap;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 32'hE21BD00C;
  logic [31:0] rdq[$];
  logic [11:0] slq[$];
  logic rd_dph = 1'b0;
  logic mon_on = 1'b0;
  logic [10:0] prev = 11'h000;
  logic [31:0] wv;
  logic [4:0] chs [5] = '{5'h03, 5'h07, 5'h0C, 5'h1F, 5'h15};

  always #2.5 clk = ~clk;

  acst_top u_acst_top (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .conv_done(conv_done),
    .slot_channel(slot_channel), .slot_index(slot_index), .slot_last(slot_last),
    .seq_running(seq_running), .seq_wrap(seq_wrap)
  );

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t read data %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_slot(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t slot outputs %h, expected %h", $time, got, exp);
    end
  endtask

  // Caller stands just after a rising edge; no pipelining of transfers
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= w ? d : ~d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rdq.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask

  // Watches read data phases and every change of the slot outputs
  always @(posedge clk) begin
    if (hready === 1'b1) begin
      if (rd_dph) cmp_rd(hrdata, rdq.pop_front());
      if (rd_dph) cmp_rd({31'h0000_0000, hresp}, 32'h0000_0000);
      rd_dph <= hsel && htrans[1] && !hwrite;
    end
    if (mon_on && {slot_index, slot_channel, slot_last} !== prev) begin
      cmp_slot({slot_index, slot_channel, slot_last, seq_wrap}, slq.pop_front());
    end
    prev <= {slot_index, slot_channel, slot_last};
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      $display("[ERR] %0t run did not complete", $time);
      final_report;
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rd(32'(4 * i), 32'h8080_8080);
    for (int i = 0; i < 8; i++) begin
      wv = $random(seed);
      bus(32'(4 * i), 1'b1, wv);
      rd(32'(4 * i), wv & 32'h9F9F_9F9F);
    end
    bus(32'h0000_0004, 1'b1, 32'hFFFF_FFFF);
    rd(32'h0000_0004, 32'h9F9F_9F9F);
    // Unmapped place: write dropped, reads zero
    bus(32'h0000_0020, 1'b1, 32'hFFFF_FFFF);
    rd(32'h0000_0020, 32'h0000_0000);
    // Five-slot sequence crossing from entry 0 into entry 1
    bus(32'h0000_0000, 1'b1, 32'h1F0C_0703);
    bus(32'h0000_0004, 1'b1, 32'h8080_8095);
    // Steps while idle must be ignored
    @(posedge clk);
    conv_done <= 1'b1;
    repeat (3) @(posedge clk);
    conv_done <= 1'b0;
    bus(32'h0000_0040, 1'b1, 32'h0000_0001);
    rd(32'h0000_0040, 32'h0000_0001);
    for (int i = 0; i < 20 && seq_running !== 1'b1; i++) @(posedge clk);
    cmp_rd({31'h0000_0000, seq_running}, 32'h0000_0001);
    repeat (2) @(posedge clk);
    cmp_slot({slot_index, slot_channel, slot_last, seq_wrap}, {5'h00, 5'h03, 2'h0});
    mon_on <= 1'b1;
    for (int k = 1; k <= 10; k++) begin
      slq.push_back({5'(k % 5), chs[k % 5], 1'((k % 5) == 4), 1'((k % 5) == 0)});
    end
    // Back-to-back steps, two full laps with wrap
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      conv_done <= 1'b1;
    end
    @(posedge clk);
    conv_done <= 1'b0;
    repeat (4) @(posedge clk);
    mon_on <= 1'b0;
    cmp_rd(32'(slq.size()), 32'h0000_0000);
    rd(32'h0000_0044, 32'h0000_0100);
    // Two more steps, then a restart must bring the pointer back to slot zero
    @(posedge clk);
    conv_done <= 1'b1;
    repeat (2) @(posedge clk);
    conv_done <= 1'b0;
    rd(32'h0000_0044, 32'h0000_0102);
    bus(32'h0000_0040, 1'b1, 32'h0000_0003);
    rd(32'h0000_0040, 32'h0000_0001);
    rd(32'h0000_0044, 32'h0000_0100);
    // Let the monitor take the last data phase before the verdict
    @(posedge clk);
    cmp_rd(32'(rdq.size()), 32'h0000_0000);
    final_report;
  end
endmodule
`default_nettype wire

/* src/acst_map.svh */
// Offsets, field positions and reset values of the channel sequence table
// Functional notes
// - Each slot holds a five-bit input select at 28:24, 20:16, 12:8 (and 4:0).
// - Each slot has an end flag at bits 23, 15, 7 (and 31).
// - After a slot with end flag set, sequencing restarts at the first slot.
// - Gap bits 22:21 and 14:13 are read-only, read zero, ignore writes.
// - Reset sets every end flag to one and every input select to zero.
// - Software writes and reads back selects and end flags; values are held.
// - Eight 32-bit entries at word offsets from zero, four slots each.
`ifndef ACST_MAP_SVH
`define ACST_MAP_SVH

`define ACST_ENTRIES 8
`define ACST_SLOTS_PER_ENTRY 4
`define ACST_SLOTS 32
`define ACST_OFS_ENTRY0 8'h00
`define ACST_OFS_CTRL 8'h40
`define ACST_OFS_STATUS 8'h44
`define ACST_SLOT_STRIDE 8
`define ACST_CHAN_LSB 0
`define ACST_CHAN_W 5
`define ACST_LAST_BIT 7
`define ACST_ENTRY_RW_MASK 32'h9F9F_9F9F
`define ACST_ENTRY_RESET 32'h8080_8080
`define ACST_CHAN_RESET 5'h00
`define ACST_LAST_RESET 1'h1
`define ACST_CTRL_ENABLE_BIT 0
`define ACST_CTRL_RESTART_BIT 1
`define ACST_STAT_RUNNING_BIT 8
`define ACST_STAT_LAST_BIT 9
`define ACST_LAST_SLOT 5'h1F

`endif

/* src/acst_pkg.sv */
// Types shared by the channel sequence table modules
package acst_pkg;
  typedef enum logic [0:0] {
    ACST_IDLE = 1'b0,
    ACST_RUN = 1'b1
  } acst_state_type;
  typedef logic [4:0] acst_slot_type;
  typedef logic [4:0] acst_chan_type;
endpackage

/* src/acst_step_if.sv */
// Link between the register side and the slot stepper
`timescale 1ns/1ps
`default_nettype none
interface acst_step_if;
  logic enable;
  logic restart;
  logic conv_done;
  logic cur_last;
  acst_pkg::acst_slot_type slot_idx;
  logic running;
  logic wrap;
  modport seq (input enable, input restart, input conv_done, input cur_last,
    output slot_idx, output running, output wrap);
  modport ctl (output enable, output restart, output conv_done, output cur_last,
    input slot_idx, input running, input wrap);
endinterface
`default_nettype wire

/* src/acst_stepper.sv */
// Slot stepper: walks the sequence table one conversion at a time
`timescale 1ns/1ps
`default_nettype none
`include "acst_map.svh"
module acst_stepper (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control link
  acst_step_if.seq step
);
  acst_pkg::acst_state_type state_r;
  acst_pkg::acst_slot_type idx_r;
  logic wrap_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= acst_pkg::ACST_IDLE;
    end else begin
      unique case (state_r)
        acst_pkg::ACST_IDLE: begin
          if (step.enable) begin
            state_r <= acst_pkg::ACST_RUN;
          end
        end
        acst_pkg::ACST_RUN: begin
          if (!step.enable) begin
            state_r <= acst_pkg::ACST_IDLE;
          end
        end
      endcase
    end
  end

  // Slot pointer; end flag or top of table sends it back to slot zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      idx_r <= 5'h00;
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= 1'b0;
      if (state_r == acst_pkg::ACST_IDLE || step.restart) begin
        idx_r <= 5'h00;
      end else if (step.conv_done) begin
        if (step.cur_last || idx_r == `ACST_LAST_SLOT) begin
          idx_r <= 5'h00;
          wrap_r <= 1'b1;
        end else begin
          idx_r <= idx_r + 5'h01;
        end
      end
    end
  end

  assign step.slot_idx = idx_r;
  assign step.running = (state_r == acst_pkg::ACST_RUN);
  assign step.wrap = wrap_r;

  chk_end_restart: assert property (@(posedge clk) disable iff (reset)
    (state_r == acst_pkg::ACST_RUN && step.enable && !step.restart && step.conv_done
      && step.cur_last) |=> (idx_r == 5'h00 && wrap_r))
    else $error("end flag did not restart at slot zero");
  chk_ascend_order: assert property (@(posedge clk) disable iff (reset)
    (state_r == acst_pkg::ACST_RUN && !step.restart && step.conv_done && !step.cur_last
      && idx_r != `ACST_LAST_SLOT) |=> (idx_r == $past(idx_r) + 5'h01))
    else $error("slot pointer did not step up by one");
endmodule
`default_nettype wire

/* src/acst_top.sv */
// Channel sequence table with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "acst_map.svh"
module acst_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  input wire logic conv_done,
  output logic [4:0] slot_channel,
  output logic [4:0] slot_index,
  output logic slot_last,
  output logic seq_running,
  output logic seq_wrap
);
  // Table storage, one select and one end flag per slot
  logic [4:0] chan_q [`ACST_SLOTS];
  logic last_q [`ACST_SLOTS];

  logic wr_pend_r;
  logic [5:0] wr_idx_r;
  logic enable_r;
  logic restart_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic [4:0] slot_channel_r;
  logic [4:0] slot_index_r;
  logic slot_last_r;
  logic seq_running_r;
  logic seq_wrap_r;
  logic first_r;

  logic addr_ok;
  logic [5:0] addr_idx;
  logic [31:0] rd_nxt;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  acst_step_if step ();

  acst_stepper u_stepper (
    .clk(clk),
    .reset(reset),
    .step(step)
  );

  // Entry word for entry e, gap and reserved bits forced to zero
  function automatic logic [31:0] entry_word(input logic [2:0] e);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int s = 0; s < `ACST_SLOTS_PER_ENTRY; s++) begin
      w[s * `ACST_SLOT_STRIDE + `ACST_CHAN_LSB +: `ACST_CHAN_W] =
        chan_q[{e, 2'(s)}];
      w[s * `ACST_SLOT_STRIDE + `ACST_LAST_BIT] = last_q[{e, 2'(s)}];
    end
    return w & `ACST_ENTRY_RW_MASK;
  endfunction

  // Word index is in the entry range
  function automatic logic is_entry(input logic [5:0] idx);
    return idx < 6'(`ACST_ENTRIES);
  endfunction

  assign addr_ok = hsel && htrans[1] && hready;
  assign addr_idx = haddr[7:2];

  assign ctrl_word = {30'h0000_0000, 1'b0, enable_r};
  assign stat_word = {22'h00_0000, step.cur_last, step.running, 3'h0, step.slot_idx};

  // Read data, with the pending write forwarded so back-to-back reads see it
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wr_pend_r && wr_idx_r == addr_idx && is_entry(addr_idx)) begin
      rd_nxt = hwdata & `ACST_ENTRY_RW_MASK;
    end else if (is_entry(addr_idx)) begin
      rd_nxt = entry_word(addr_idx[2:0]);
    end else if ({addr_idx, 2'h0} == `ACST_OFS_CTRL) begin
      if (wr_pend_r && wr_idx_r == addr_idx) begin
        rd_nxt = {31'h0000_0000, hwdata[`ACST_CTRL_ENABLE_BIT]};
      end else begin
        rd_nxt = ctrl_word;
      end
    end else if ({addr_idx, 2'h0} == `ACST_OFS_STATUS) begin
      rd_nxt = stat_word;
    end
  end

  // Address phase capture; zero wait states, every answer OKAY
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 6'h00;
      hreadyout_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok && hwrite) begin
        wr_idx_r <= addr_idx;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_r <= rd_nxt;
    end
  end

  // Slot storage; only select and end bits exist, so gap writes are lost
  for (genvar g = 0; g < `ACST_SLOTS; g++) begin : g_slot
    localparam int E = g / `ACST_SLOTS_PER_ENTRY;
    localparam int S = g % `ACST_SLOTS_PER_ENTRY;
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        chan_q[g] <= `ACST_CHAN_RESET;
        last_q[g] <= `ACST_LAST_RESET;
      end else if (wr_pend_r && wr_idx_r == 6'(E)) begin
        chan_q[g] <= hwdata[S * `ACST_SLOT_STRIDE + `ACST_CHAN_LSB +: `ACST_CHAN_W];
        last_q[g] <= hwdata[S * `ACST_SLOT_STRIDE + `ACST_LAST_BIT];
      end
    end
  end

  // Control: enable level and a self-clearing restart strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      restart_r <= 1'b0;
      if (wr_pend_r && {wr_idx_r, 2'h0} == `ACST_OFS_CTRL) begin
        enable_r <= hwdata[`ACST_CTRL_ENABLE_BIT];
        restart_r <= hwdata[`ACST_CTRL_RESTART_BIT];
      end
    end
  end

  assign step.enable = enable_r;
  assign step.restart = restart_r;
  assign step.conv_done = conv_done;
  assign step.cur_last = last_q[step.slot_idx];

  // Converter outputs lag the pointer by one cycle to stay registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      slot_channel_r <= `ACST_CHAN_RESET;
      slot_index_r <= 5'h00;
      slot_last_r <= `ACST_LAST_RESET;
      seq_running_r <= 1'b0;
      seq_wrap_r <= 1'b0;
    end else begin
      slot_channel_r <= chan_q[step.slot_idx];
      slot_index_r <= step.slot_idx;
      slot_last_r <= step.cur_last;
      seq_running_r <= step.running;
      seq_wrap_r <= step.wrap;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign slot_channel = slot_channel_r;
  assign slot_index = slot_index_r;
  assign slot_last = slot_last_r;
  assign seq_running = seq_running_r;
  assign seq_wrap = seq_wrap_r;

  // Marks the first clocked cycle after reset release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      first_r <= 1'b1;
    end else begin
      first_r <= 1'b0;
    end
  end

  chk_slot_select: assert property (@(posedge clk) disable iff (reset)
    !first_r |-> slot_channel_r == $past(chan_q[step.slot_idx]))
    else $error("slot channel does not follow selected slot");
  chk_slot_endflag: assert property (@(posedge clk) disable iff (reset)
    !first_r |-> slot_last_r == $past(last_q[step.slot_idx]))
    else $error("slot end flag does not follow selected slot");
  chk_wrap_output: assert property (@(posedge clk) disable iff (reset)
    step.wrap |=> seq_wrap_r && slot_index_r == 5'h00)
    else $error("wrap not shown on converter outputs");
  chk_gap_zero: assert property (@(posedge clk) disable iff (reset)
    (hrdata_r[22:21] == 2'h0 && hrdata_r[14:13] == 2'h0 && hrdata_r[30:29] == 2'h0)
    || !$past(is_entry(haddr[7:2])))
    else $error("gap bits read nonzero");
  chk_reset_table: assert property (@(posedge clk) disable iff (reset)
    first_r |-> (entry_word(3'h0) == `ACST_ENTRY_RESET
      && entry_word(3'h7) == `ACST_ENTRY_RESET))
    else $error("table reset value wrong");
  chk_write_hold: assert property (@(posedge clk) disable iff (reset)
    (wr_pend_r && is_entry(wr_idx_r)) |=>
      entry_word($past(wr_idx_r[2:0])) == ($past(hwdata) & `ACST_ENTRY_RW_MASK))
    else $error("written entry not held");
  chk_entry_read: assert property (@(posedge clk) disable iff (reset)
    (addr_ok && !hwrite && is_entry(addr_idx) && !wr_pend_r) |=>
      hrdata_r == entry_word($past(addr_idx[2:0])))
    else $error("entry read returned wrong word");
  chk_order_out: assert property (@(posedge clk) disable iff (reset)
    // Output shows the pointer one edge after it moves, so restart and idle look back two
    (seq_running_r && $past(step.running) && $past(step.running, 2) && !$past(step.wrap)
      && !$past(restart_r, 2)
      && slot_index_r != $past(slot_index_r)) |-> slot_index_r == $past(slot_index_r) + 5'h01)
    else $error("slot index not ascending");
endmodule
`default_nettype wire
